// >>> common/pil_regs.svh
/*
  Register indices, field positions, reset values and timing counts of the
  interrupt latch unit. Assumes inclusion by bare name from design files.
*/
`ifndef PIL_REGS_SVH
`define PIL_REGS_SVH

// Register indices; byte address is four times the index
`define PIL_IDX_LATCH_EXT  8'h2E
`define PIL_IDX_LATCH_LOW  8'h3C
`define PIL_IDX_LATCH_HIGH 8'h3D
`define PIL_IDX_EN_EXT     8'h2C
`define PIL_IDX_EN_LOW     8'h3A
`define PIL_IDX_EN_HIGH    8'h3B
`define PIL_IDX_CTRL       8'h40
`define PIL_IDX_STATUS     8'h41

// Control register fields and reset value
`define PIL_CTRL_EXT0_EN   0
`define PIL_CTRL_TRAP_SEL  1
`define PIL_CTRL_WDT_SEL   2
`define PIL_CTRL_RESET     8'h06

// Source positions
`define PIL_SRC_TRAP       2
`define PIL_SRC_WDT        3
`define PIL_SRC_EXT0       4
`define PIL_SRC_ADC        15
`define PIL_SRC_HI_FIRST   16

// Vectors
`define PIL_VEC_SOFT       16'hFFFC
`define PIL_VEC_TRAP       16'hFFFA
`define PIL_VEC_WDT        16'hFFF8
`define PIL_VEC_LO_BASE    16'hFFF6
`define PIL_VEC_HI_BASE    16'hFFBE

// Acceptance length in machine cycles, system clocks per machine cycle
`define PIL_ACCEPT_MCYC    8
`define PIL_CLKS_PER_MCYC  4

// AXI responses
`define PIL_RESP_OKAY      2'h0
`define PIL_RESP_SLVERR    2'h2

`endif

// >>> common/pil_pkg.sv
/*
  Types of the interrupt latch unit.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package pil_pkg;
  typedef enum logic [1:0] {
    PIL_ST_IDLE   = 2'b01,
    PIL_ST_ACCEPT = 2'b10
  } pil_state_type;
  typedef logic [23:0] pil_src_type;
  typedef logic [15:0] pil_vector_type;
  typedef logic [4:0]  pil_idx_type;
endpackage

// >>> common/pil_reg_if.sv
/*
  Register access strobes between the bus slave and the register file.
  Assumes both ends run on the system clock.
*/
interface pil_reg_if;
  logic       wr_en;
  logic [7:0] wr_idx;
  logic [7:0] wr_data;
  logic       wr_ok;
  logic       rd_en;
  logic [7:0] rd_idx;
  logic [7:0] rd_data;
  logic       rd_ok;
  modport slave (output wr_en, wr_idx, wr_data, rd_en, rd_idx,
                 input  wr_ok, rd_data, rd_ok);
  modport regs  (input  wr_en, wr_idx, wr_data, rd_en, rd_idx,
                 output wr_ok, rd_data, rd_ok);
endinterface

// >>> rtl/pil_prio_enc.sv
/*
  Fixed priority encoder: lowest set index wins.
  Assumes a purely combinational context.
*/
module pil_prio_enc #(
  parameter int N = 24,
  parameter int W = 5
) (
  input  wire logic [N-1:0] req_in,
  output logic              hit_out,
  output logic [W-1:0]      idx_out
);
  always_comb
  begin
    hit_out = 1'b0;
    idx_out = '0;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (req_in[i])
      begin
        hit_out = 1'b1;
        idx_out = W'(i);
      end
    end
  end
endmodule

// >>> rtl/pil_axil_slave.sv
/*
  AXI4-Lite slave turning bus transfers into one-cycle register strobes.
  Assumes the register side answers reads and decodes in the same cycle.
*/
`include "pil_regs.svh"
module pil_axil_slave (
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  input  wire logic [9:0]  awaddr_in,
  input  wire logic        awvalid_in,
  output logic             awready_out,
  input  wire logic [31:0] wdata_in,
  input  wire logic [3:0]  wstrb_in,
  input  wire logic        wvalid_in,
  output logic             wready_out,
  output logic [1:0]       bresp_out,
  output logic             bvalid_out,
  input  wire logic        bready_in,
  input  wire logic [9:0]  araddr_in,
  input  wire logic        arvalid_in,
  output logic             arready_out,
  output logic [31:0]      rdata_out,
  output logic [1:0]       rresp_out,
  output logic             rvalid_out,
  input  wire logic        rready_in,
  pil_reg_if.slave         rb
);
  logic       aw_full_q, aw_full_d, w_full_q, w_full_d, bvalid_q, bvalid_d;
  logic       rvalid_q, rvalid_d, wlane_q, wlane_d;
  logic [7:0] awidx_q, awidx_d, wbyte_q, wbyte_d, rbyte_q, rbyte_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic       fire;

  assign awready_out = !aw_full_q;
  assign wready_out  = !w_full_q;
  assign arready_out = !rvalid_q;
  assign bvalid_out  = bvalid_q;
  assign bresp_out   = bresp_q;
  assign rvalid_out  = rvalid_q;
  assign rresp_out   = rresp_q;
  assign rdata_out   = {24'h000000, rbyte_q};
  assign fire        = aw_full_q && w_full_q && !bvalid_q;
  // Lane 0 unwritten leaves the register alone but still answers
  assign rb.wr_en    = fire && wlane_q;
  assign rb.wr_idx   = awidx_q;
  assign rb.wr_data  = wbyte_q;
  assign rb.rd_en    = arvalid_in && !rvalid_q;
  assign rb.rd_idx   = araddr_in[9:2];

  always_comb
  begin
    aw_full_d = aw_full_q;
    w_full_d  = w_full_q;
    awidx_d   = awidx_q;
    wbyte_d   = wbyte_q;
    wlane_d   = wlane_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rresp_d   = rresp_q;
    rbyte_d   = rbyte_q;
    if (awvalid_in && !aw_full_q)
    begin
      aw_full_d = 1'b1;
      awidx_d   = awaddr_in[9:2];
    end
    if (wvalid_in && !w_full_q)
    begin
      w_full_d = 1'b1;
      wbyte_d  = wdata_in[7:0];
      wlane_d  = wstrb_in[0];
    end
    if (fire)
    begin
      aw_full_d = 1'b0;
      w_full_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = rb.wr_ok ? `PIL_RESP_OKAY : `PIL_RESP_SLVERR;
    end
    else if (bvalid_q && bready_in)
      bvalid_d = 1'b0;
    if (rb.rd_en)
    begin
      rvalid_d = 1'b1;
      rbyte_d  = rb.rd_data;
      rresp_d  = rb.rd_ok ? `PIL_RESP_OKAY : `PIL_RESP_SLVERR;
    end
    else if (rvalid_q && rready_in)
      rvalid_d = 1'b0;
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awidx_q   <= 8'h00;
      wbyte_q   <= 8'h00;
      wlane_q   <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= 2'h0;
      rvalid_q  <= 1'b0;
      rresp_q   <= 2'h0;
      rbyte_q   <= 8'h00;
    end
    else
    begin
      aw_full_q <= aw_full_d;
      w_full_q  <= w_full_d;
      awidx_q   <= awidx_d;
      wbyte_q   <= wbyte_d;
      wlane_q   <= wlane_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rresp_q   <= rresp_d;
      rbyte_q   <= rbyte_d;
    end
  end
endmodule

// >>> rtl/pil_latch_unit.sv
/*
  Prioritized interrupt latch unit: request latches, enables, priority
  resolution, vectors and the acceptance sequence toward the CPU core.
  Assumes request pulses come from logic on the system clock and the CPU
  pulses the accept input only at an instruction boundary.
*/
// Design decision made here: register access over AXI4-Lite.
`include "pil_regs.svh"
module pil_latch_unit #(
  parameter int ACC_MCYC  = `PIL_ACCEPT_MCYC,
  parameter int MCYC_CLKS = `PIL_CLKS_PER_MCYC
) (
  input  wire logic               CLK_SYS_IN,
  input  wire logic               RESETN_IN,
  input  wire logic [9:0]         S_AXI_AWADDR_IN,
  input  wire logic               S_AXI_AWVALID_IN,
  output logic                    S_AXI_AWREADY_OUT,
  input  wire logic [31:0]        S_AXI_WDATA_IN,
  input  wire logic [3:0]         S_AXI_WSTRB_IN,
  input  wire logic               S_AXI_WVALID_IN,
  output logic                    S_AXI_WREADY_OUT,
  output logic [1:0]              S_AXI_BRESP_OUT,
  output logic                    S_AXI_BVALID_OUT,
  input  wire logic               S_AXI_BREADY_IN,
  input  wire logic [9:0]         S_AXI_ARADDR_IN,
  input  wire logic               S_AXI_ARVALID_IN,
  output logic                    S_AXI_ARREADY_OUT,
  output logic [31:0]             S_AXI_RDATA_OUT,
  output logic [1:0]              S_AXI_RRESP_OUT,
  output logic                    S_AXI_RVALID_OUT,
  input  wire logic               S_AXI_RREADY_IN,
  input  wire logic [23:4]        SRC_REQ_IN,
  input  wire logic               FETCH_TRAP_IRQ_IN,
  input  wire logic               WATCHDOG_IRQ_IN,
  input  wire logic               SOFTWARE_TRAP_IRQ_IN,
  input  wire logic               UNDEFINED_OPCODE_IRQ_IN,
  input  wire logic               ACCEPT_IN,
  input  wire logic               ENABLE_IRQ_INSTRUCTION_IN,
  input  wire logic               DISABLE_IRQ_INSTRUCTION_IN,
  input  wire logic               MASTER_EN_RESTORE_IN,
  input  wire logic               MASTER_EN_RESTORE_VAL_IN,
  output logic                    IRQ_REQ_OUT,
  output pil_pkg::pil_vector_type VECTOR_OUT,
  output logic                    MASTER_EN_STACKED_OUT,
  output logic                    ACCEPT_BUSY_OUT,
  output logic                    ACCEPT_DONE_OUT,
  output logic                    TRAP_RESET_OUT,
  output logic                    WATCHDOG_RESET_OUT
);
  import pil_pkg::*;

  pil_reg_if rb ();

  pil_src_type    latch_q, latch_d, en_q, en_d, latch_set, sw_clr, acc_clr, elig;
  logic [7:0]     ctrl_q, ctrl_d;
  logic           master_q, master_d, soft_req, hit, start, adc_lost, mtick;
  pil_idx_type    hit_idx, acc_idx_q, acc_idx_d;
  pil_state_type  state_q, state_d;
  logic [3:0]     mcnt_q, mcnt_d;
  logic [2:0]     mdiv_q, mdiv_d;
  pil_vector_type vec_q, vec_d, vec_c;
  logic           done_q, done_d, stacked_q, stacked_d;
  logic           trap_rst_q, trap_rst_d, wdt_rst_q, wdt_rst_d;

  pil_axil_slave u_bus (
    .clk_in      (CLK_SYS_IN),
    .resetn_in   (RESETN_IN),
    .awaddr_in   (S_AXI_AWADDR_IN),
    .awvalid_in  (S_AXI_AWVALID_IN),
    .awready_out (S_AXI_AWREADY_OUT),
    .wdata_in    (S_AXI_WDATA_IN),
    .wstrb_in    (S_AXI_WSTRB_IN),
    .wvalid_in   (S_AXI_WVALID_IN),
    .wready_out  (S_AXI_WREADY_OUT),
    .bresp_out   (S_AXI_BRESP_OUT),
    .bvalid_out  (S_AXI_BVALID_OUT),
    .bready_in   (S_AXI_BREADY_IN),
    .araddr_in   (S_AXI_ARADDR_IN),
    .arvalid_in  (S_AXI_ARVALID_IN),
    .arready_out (S_AXI_ARREADY_OUT),
    .rdata_out   (S_AXI_RDATA_OUT),
    .rresp_out   (S_AXI_RRESP_OUT),
    .rvalid_out  (S_AXI_RVALID_OUT),
    .rready_in   (S_AXI_RREADY_IN),
    .rb          (rb.slave)
  );

  // Non-maskable latches ignore enables; maskable ones are gated
  always_comb
  begin
    elig = '0;
    elig[`PIL_SRC_WDT:`PIL_SRC_TRAP] = latch_q[`PIL_SRC_WDT:`PIL_SRC_TRAP];
    elig[23:4] = latch_q[23:4] & en_q[23:4] & {20{master_q}};
    elig[`PIL_SRC_EXT0] = elig[`PIL_SRC_EXT0] & ctrl_q[`PIL_CTRL_EXT0_EN];
  end

  pil_prio_enc #(.N(24), .W(5)) u_enc (
    .req_in  (elig),
    .hit_out (hit),
    .idx_out (hit_idx)
  );

  // Software and undefined traps outrank latched ones within the shared level
  assign soft_req = SOFTWARE_TRAP_IRQ_IN || UNDEFINED_OPCODE_IRQ_IN;
  assign start    = (state_q == PIL_ST_IDLE) && ACCEPT_IN && (soft_req || hit);
  assign adc_lost = start && !soft_req && (hit_idx > 5'(`PIL_SRC_ADC));
  assign IRQ_REQ_OUT = (state_q == PIL_ST_IDLE) && (soft_req || hit);

  always_comb
  begin
    if (soft_req)
      vec_c = `PIL_VEC_SOFT;
    else if (hit_idx == 5'(`PIL_SRC_TRAP))
      vec_c = `PIL_VEC_TRAP;
    else if (hit_idx == 5'(`PIL_SRC_WDT))
      vec_c = `PIL_VEC_WDT;
    else if (hit_idx < 5'(`PIL_SRC_HI_FIRST))
      vec_c = `PIL_VEC_LO_BASE - {10'h000, hit_idx - 5'(`PIL_SRC_EXT0), 1'b0};
    else
      vec_c = `PIL_VEC_HI_BASE - {10'h000, hit_idx - 5'(`PIL_SRC_HI_FIRST), 1'b0};
  end

  // Register file next values
  always_comb
  begin
    latch_set = '0;
    latch_set[23:4] = SRC_REQ_IN;
    latch_set[`PIL_SRC_TRAP] = FETCH_TRAP_IRQ_IN && !ctrl_q[`PIL_CTRL_TRAP_SEL];
    latch_set[`PIL_SRC_WDT]  = WATCHDOG_IRQ_IN && !ctrl_q[`PIL_CTRL_WDT_SEL];
    sw_clr  = '0;
    acc_clr = '0;
    en_d     = en_q;
    ctrl_d   = ctrl_q;
    master_d = master_q;
    rb.wr_ok = 1'b1;
    if (rb.wr_en)
    begin
      unique case (rb.wr_idx)
        `PIL_IDX_LATCH_LOW:  sw_clr[7:0]   = ~rb.wr_data;
        `PIL_IDX_LATCH_HIGH: sw_clr[15:8]  = ~rb.wr_data;
        `PIL_IDX_LATCH_EXT:  sw_clr[23:16] = ~rb.wr_data;
        `PIL_IDX_EN_LOW:
        begin
          en_d[7:4] = rb.wr_data[7:4];
          master_d  = rb.wr_data[0];
        end
        `PIL_IDX_EN_HIGH:    en_d[15:8]  = rb.wr_data;
        `PIL_IDX_EN_EXT:     en_d[23:16] = rb.wr_data;
        `PIL_IDX_CTRL:       ctrl_d      = rb.wr_data & 8'h07;
        `PIL_IDX_STATUS:     rb.wr_ok    = 1'b1;
        default:             rb.wr_ok    = 1'b0;
      endcase
    end
    if (ENABLE_IRQ_INSTRUCTION_IN)
      master_d = 1'b1;
    if (DISABLE_IRQ_INSTRUCTION_IN)
      master_d = 1'b0;
    if (MASTER_EN_RESTORE_IN)
      master_d = MASTER_EN_RESTORE_VAL_IN;
    if (start)
    begin
      master_d = 1'b0;
      if (!soft_req)
        acc_clr = 24'h000001 << hit_idx;
    end
    if (adc_lost)
      latch_set[`PIL_SRC_ADC] = 1'b0;
    // Set wins over any clear arriving in the same cycle; writes only clear
    latch_d = ((latch_q & ~sw_clr & ~acc_clr) | latch_set) & 24'hFFFFFC;
    en_d[3:0] = 4'h0;
  end

  always_comb
  begin
    rb.rd_data = 8'h00;
    rb.rd_ok   = 1'b1;
    unique case (rb.rd_idx)
      `PIL_IDX_LATCH_LOW:  rb.rd_data = latch_q[7:0];
      `PIL_IDX_LATCH_HIGH: rb.rd_data = latch_q[15:8];
      `PIL_IDX_LATCH_EXT:  rb.rd_data = latch_q[23:16];
      `PIL_IDX_EN_LOW:     rb.rd_data = {en_q[7:4], 3'h0, master_q};
      `PIL_IDX_EN_HIGH:    rb.rd_data = en_q[15:8];
      `PIL_IDX_EN_EXT:     rb.rd_data = en_q[23:16];
      `PIL_IDX_CTRL:       rb.rd_data = ctrl_q;
      `PIL_IDX_STATUS:     rb.rd_data = {state_q == PIL_ST_ACCEPT, IRQ_REQ_OUT, 1'b0, acc_idx_q};
      default:             rb.rd_ok   = 1'b0;
    endcase
  end

  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      latch_q  <= '0;
      en_q     <= '0;
      master_q <= 1'b0;
      ctrl_q   <= `PIL_CTRL_RESET;
    end
    else
    begin
      latch_q  <= latch_d;
      en_q     <= en_d;
      master_q <= master_d;
      ctrl_q   <= ctrl_d;
    end
  end

  // Acceptance sequence timed in machine cycles
  assign mtick = (mdiv_q == 3'(MCYC_CLKS - 1));

  always_comb
  begin
    state_d    = state_q;
    mdiv_d     = 3'h0;
    mcnt_d     = mcnt_q;
    acc_idx_d  = acc_idx_q;
    vec_d      = vec_q;
    stacked_d  = stacked_q;
    done_d     = 1'b0;
    trap_rst_d = FETCH_TRAP_IRQ_IN && ctrl_q[`PIL_CTRL_TRAP_SEL];
    wdt_rst_d  = WATCHDOG_IRQ_IN && ctrl_q[`PIL_CTRL_WDT_SEL];
    unique case (state_q)
      PIL_ST_IDLE:
      begin
        if (start)
        begin
          state_d   = PIL_ST_ACCEPT;
          mcnt_d    = 4'h0;
          acc_idx_d = soft_req ? 5'h00 : hit_idx;
          vec_d     = vec_c;
          stacked_d = master_q;
        end
      end
      PIL_ST_ACCEPT:
      begin
        mdiv_d = mtick ? 3'h0 : mdiv_q + 3'h1;
        if (mtick)
        begin
          mcnt_d = mcnt_q + 4'h1;
          if (mcnt_q == 4'(ACC_MCYC - 1))
          begin
            state_d = PIL_ST_IDLE;
            done_d  = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      state_q    <= PIL_ST_IDLE;
      mdiv_q     <= 3'h0;
      mcnt_q     <= 4'h0;
      acc_idx_q  <= 5'h00;
      vec_q      <= 16'h0000;
      stacked_q  <= 1'b0;
      done_q     <= 1'b0;
      trap_rst_q <= 1'b0;
      wdt_rst_q  <= 1'b0;
    end
    else
    begin
      state_q    <= state_d;
      mdiv_q     <= mdiv_d;
      mcnt_q     <= mcnt_d;
      acc_idx_q  <= acc_idx_d;
      vec_q      <= vec_d;
      stacked_q  <= stacked_d;
      done_q     <= done_d;
      trap_rst_q <= trap_rst_d;
      wdt_rst_q  <= wdt_rst_d;
    end
  end

  assign VECTOR_OUT            = vec_q;
  assign MASTER_EN_STACKED_OUT = stacked_q;
  assign ACCEPT_BUSY_OUT       = (state_q == PIL_ST_ACCEPT);
  assign ACCEPT_DONE_OUT       = done_q;
  assign TRAP_RESET_OUT        = trap_rst_q;
  assign WATCHDOG_RESET_OUT    = wdt_rst_q;

  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RESETN_IN);

  property p_acc_clears;
    start && !soft_req && !latch_set[hit_idx] |=> !latch_q[$past(hit_idx)];
  endproperty
  a_acc_clears: assert property (p_acc_clears) else $error("latch kept");
  property p_mask_gate;
    start && !soft_req && hit_idx >= 5'd4 |-> master_q && en_q[hit_idx];
  endproperty
  a_mask_gate: assert property (p_mask_gate) else $error("masked taken");
  property p_lowest;
    hit |-> (elig & ((24'h000001 << hit_idx) - 24'h000001)) == 24'h000000;
  endproperty
  a_lowest: assert property (p_lowest) else $error("wrong priority");
  property p_vec_adc;
    start && !soft_req && hit_idx == 5'd15 |=> VECTOR_OUT == 16'hFFE0;
  endproperty
  a_vec_adc: assert property (p_vec_adc) else $error("bad vector");
  property p_soft_first;
    start && soft_req |=> VECTOR_OUT == 16'hFFFC &&
      latch_q[3:2] == $past(latch_q[3:2] | latch_set[3:2]);
  endproperty
  a_soft_first: assert property (p_soft_first) else $error("soft trap lost");
  property p_master_off;
    start |=> !master_q && ACCEPT_BUSY_OUT && MASTER_EN_STACKED_OUT == $past(master_q);
  endproperty
  a_master_off: assert property (p_master_off) else $error("master left on");
  property p_accept_len;
    start |-> ##32 ACCEPT_BUSY_OUT ##1 (ACCEPT_DONE_OUT && !ACCEPT_BUSY_OUT);
  endproperty
  a_accept_len: assert property (p_accept_len) else $error("accept length");
  property p_trap_reset;
    FETCH_TRAP_IRQ_IN && ctrl_q[1] && !latch_q[2] |=> TRAP_RESET_OUT && !latch_q[2];
  endproperty
  a_trap_reset: assert property (p_trap_reset) else $error("trap not reset");
  property p_no_sw_set;
    latch_set == 24'h000000 |=> (latch_q & ~$past(latch_q)) == 24'h000000;
  endproperty
  a_no_sw_set: assert property (p_no_sw_set) else $error("latch set by write");
  property p_set_sticks;
    SRC_REQ_IN[5] |=> latch_q[5];
  endproperty
  a_set_sticks: assert property (p_set_sticks) else $error("request lost");
  property p_wr_clear;
    rb.wr_en && rb.wr_idx == 8'h3C && !rb.wr_data[6] && !latch_set[6] && !start |=> !latch_q[6];
  endproperty
  a_wr_clear: assert property (p_wr_clear) else $error("clear failed");
  c_accept_mask: cover property (start && !soft_req && hit_idx > 5'd3);
  c_accept_nmi: cover property (start && hit_idx == 5'd3);
  c_adc_lost: cover property (adc_lost && SRC_REQ_IN[15]);
endmodule

// >>> bench/pil_cpu_model.sv
/*
  Stand-in for the CPU core: takes a presented interrupt at an instruction
  boundary. Assumes the latch unit runs on the same clock.
*/
module pil_cpu_model (
  input  wire logic clk_in,
  input  wire logic go_in,
  input  wire logic irq_in,
  input  wire logic busy_in,
  output logic      accept_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic accept_d;
  // Go low stands for a long instruction still running
  always_comb accept_d = go_in && irq_in && !busy_in && !accept_out;
  always_ff @(posedge clk_in) accept_out <= accept_d;
endmodule

// >>> bench/test_prioritized_interrupt_latch_unit.sv
/*
  Self-checking bench of the interrupt latch unit.
  Assumes the unit with default parameters and the CPU stand-in.
*/
module test_prioritized_interrupt_latch_unit;
  timeunit 1ns;
  timeprecision 1ps;
  import pil_pkg::*;
  logic clk = 0, RESETN_IN = 0, S_AXI_AWVALID_IN = 0, S_AXI_WVALID_IN = 0;
  logic S_AXI_BREADY_IN = 0, S_AXI_ARVALID_IN = 0, S_AXI_RREADY_IN = 0;
  logic FETCH_TRAP_IRQ_IN = 0, WATCHDOG_IRQ_IN = 0, ENABLE_IRQ_INSTRUCTION_IN = 0;
  logic SOFTWARE_TRAP_IRQ_IN = 0, UNDEFINED_OPCODE_IRQ_IN = 0, DISABLE_IRQ_INSTRUCTION_IN = 0;
  logic MASTER_EN_RESTORE_IN = 0, MASTER_EN_RESTORE_VAL_IN = 0, go = 0;
  logic [9:0]  S_AXI_AWADDR_IN = 0, S_AXI_ARADDR_IN = 0;
  logic [31:0] S_AXI_WDATA_IN = 0, S_AXI_RDATA_OUT;
  logic [3:0]  S_AXI_WSTRB_IN = 4'hF;
  logic [23:4] SRC_REQ_IN = 0;
  logic [1:0]  S_AXI_BRESP_OUT, S_AXI_RRESP_OUT, rs;
  logic S_AXI_AWREADY_OUT, S_AXI_WREADY_OUT, S_AXI_BVALID_OUT, S_AXI_ARREADY_OUT;
  logic S_AXI_RVALID_OUT, ACCEPT_IN, IRQ_REQ_OUT, MASTER_EN_STACKED_OUT, ACCEPT_BUSY_OUT;
  logic ACCEPT_DONE_OUT, TRAP_RESET_OUT, WATCHDOG_RESET_OUT;
  pil_vector_type VECTOR_OUT;
  logic [7:0] rv;
  int n_mismatch = 0, checked = 0, n, k, a, b;
  always #25 clk = ~clk;
  pil_latch_unit dut_u (.CLK_SYS_IN(clk), .*);
  pil_cpu_model cpu_u (.clk_in(clk), .go_in(go), .irq_in(IRQ_REQ_OUT),
                       .busy_in(ACCEPT_BUSY_OUT), .accept_out(ACCEPT_IN));
  task results;
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input logic [31:0] s, e);
    checked++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task wr(input logic [7:0] i, d);
    @(posedge clk);
    S_AXI_AWADDR_IN <= {i, 2'h0};
    S_AXI_WDATA_IN <= {24'h0, d};
    S_AXI_AWVALID_IN <= 1;
    S_AXI_WVALID_IN <= 1;
    do @(negedge clk); while (!(S_AXI_AWREADY_OUT && S_AXI_WREADY_OUT));
    @(posedge clk);
    S_AXI_AWVALID_IN <= 0;
    S_AXI_WVALID_IN <= 0;
    S_AXI_BREADY_IN <= 1;
    do @(negedge clk); while (!S_AXI_BVALID_OUT);
    rs = S_AXI_BRESP_OUT;
    @(posedge clk);
    S_AXI_BREADY_IN <= 0;
  endtask
  task rc(input logic [7:0] i, e);
    @(posedge clk);
    S_AXI_ARADDR_IN <= {i, 2'h0};
    S_AXI_ARVALID_IN <= 1;
    S_AXI_RREADY_IN <= 1;
    do @(negedge clk); while (!S_AXI_ARREADY_OUT);
    @(posedge clk);
    S_AXI_ARVALID_IN <= 0;
    do @(negedge clk); while (!S_AXI_RVALID_OUT);
    rv = S_AXI_RDATA_OUT[7:0];
    rs = S_AXI_RRESP_OUT;
    @(posedge clk);
    S_AXI_RREADY_IN <= 0;
    chk(rv, e);
  endtask
  function automatic logic [7:0] ri(input int i);
    return i < 8 ? 8'h3C : i < 16 ? 8'h3D : 8'h2E;
  endfunction
  function automatic logic [15:0] vec(input int i);
    return i < 16 ? 16'hFFFE - 2 * i : 16'hFFDE - 2 * i;
  endfunction
  task pulse(input int i, j);
    logic [23:0] m;
    m = (24'h000001 << i) | (24'h000001 << j);
    @(posedge clk);
    SRC_REQ_IN <= m[23:4];
    @(posedge clk);
    SRC_REQ_IN <= '0;
  endtask
  task ev();
    @(posedge clk);
    {FETCH_TRAP_IRQ_IN, WATCHDOG_IRQ_IN} <= 2'h3;
    @(posedge clk);
    {FETCH_TRAP_IRQ_IN, WATCHDOG_IRQ_IN} <= 2'h0;
  endtask
  // One-cycle pulse on the master enable sources, then read the enable byte
  task ms(input logic [3:0] v, input logic [7:0] e);
    @(posedge clk);
    {ENABLE_IRQ_INSTRUCTION_IN, DISABLE_IRQ_INSTRUCTION_IN, MASTER_EN_RESTORE_IN,
     MASTER_EN_RESTORE_VAL_IN} <= v;
    @(posedge clk);
    {ENABLE_IRQ_INSTRUCTION_IN, DISABLE_IRQ_INSTRUCTION_IN, MASTER_EN_RESTORE_IN,
     MASTER_EN_RESTORE_VAL_IN} <= 4'h0;
    rc(8'h3A, e);
  endtask
  task acc(input int i, input logic m);
    n = 0;
    while (!ACCEPT_BUSY_OUT && n < 60)
    begin
      @(negedge clk);
      n++;
    end
    chk(VECTOR_OUT, vec(i));
    chk(MASTER_EN_STACKED_OUT, m);
    n = 0;
    while (ACCEPT_BUSY_OUT) @(negedge clk) n++;
    chk(n, 32);
    chk(ACCEPT_DONE_OUT, 1);
  endtask
  initial
  begin
    #(50 * 40000);
    n_mismatch++;
    results();
  end
  initial
  begin
    void'($urandom(32'h3117871D));
    repeat (20) @(posedge clk);
    RESETN_IN <= 1;
    rc(8'h2E, 0);
    rc(8'h3C, 0);
    rc(8'h3D, 0);
    rc(8'h40, 8'h06);
    rc(8'h7F, 0);
    chk(rs, 2);
    wr(8'h7F, 8'h00);
    chk(rs, 2);
    $display("reset test done");
    repeat (8)
    begin
      k = 4 + $urandom % 20;
      pulse(k, k);
      rc(ri(k), 1 << k % 8);
      wr(ri(k), 8'hFF);
      chk(rs, 0);
      rc(ri(k), 1 << k % 8);
      wr(ri(k), ~(8'h01 << k % 8));
      rc(ri(k), 0);
    end
    $display("latch test done");
    wr(8'h40, 8'h07);
    a = 0;
    repeat (6)
    begin
      k = a == 0 ? 15 : a == 1 ? 4 : 4 + $urandom % 20;
      a++;
      pulse(k, k);
      go <= 1;
      repeat (8) @(negedge clk);
      chk(IRQ_REQ_OUT, 0);
      go <= 0;
      wr(k < 8 ? 8'h3A : k < 16 ? 8'h3B : 8'h2C, 8'h01 << k % 8);
      wr(8'h3A, (k < 8 ? 8'h01 << k % 8 : 8'h00) | 8'h01);
      go <= 1;
      acc(k, 1);
      go <= 0;
      rc(ri(k), 0);
      rc(8'h3A, k < 8 ? 8'h01 << k % 8 : 8'h00);
      wr(8'h3A, 8'h00);
    end
    $display("accept test done");
    a = 5 + $urandom % 9;
    b = a + 1 + $urandom % 9;
    wr(8'h2C, 8'hFF);
    wr(8'h3B, 8'hFF);
    wr(8'h3A, 8'hFF);
    pulse(a, b);
    go <= 1;
    acc(a, 1);
    chk(IRQ_REQ_OUT, 0);
    @(posedge clk);
    ENABLE_IRQ_INSTRUCTION_IN <= 1;
    @(posedge clk);
    ENABLE_IRQ_INSTRUCTION_IN <= 0;
    acc(b, 1);
    go <= 0;
    wr(8'h3A, 8'h00);
    rc(8'h41, b);
    ms(4'h8, 8'h01);
    ms(4'h2, 8'h00);
    ms(4'h7, 8'h01);
    ms(4'hC, 8'h00);
    $display("priority test done");
    ev();
    @(negedge clk);
    chk({TRAP_RESET_OUT, WATCHDOG_RESET_OUT}, 2'h3);
    rc(8'h3C, 0);
    wr(8'h40, 8'h01);
    ev();
    rc(8'h3C, 8'h0C);
    UNDEFINED_OPCODE_IRQ_IN <= 1;
    go <= 1;
    fork
      acc(1, 0);
      begin
        wait (ACCEPT_BUSY_OUT);
        @(posedge clk);
        UNDEFINED_OPCODE_IRQ_IN <= 0;
      end
    join
    acc(2, 0);
    acc(3, 0);
    $display("trap test done");
    results();
  end
endmodule
